// file: rtl/sound_generator.sv
// Purpose: Sound generator end: byte loader, three tones and one noise.
// Assumes: Bus pins arrive asynchronously and are synchronised here.
// Notes: Analog summing is left out; each channel gives a gated level
//        and its attenuation code.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Noise rate: clock/512, /1024, /2048, tone 3
// - Feedback bit: 0 periodic, 1 white
// - Bytes accepted only while select low
// - Write strobe captures bus into register
// - Each byte takes 32 clocks to load
// - Wait low after select edge, released when done
// - CPU holds bus stable while wait low
// - First frequency byte: flag, address, low nibble
// - Second frequency byte: six upper frequency bits
// - Noise byte: flag, address, feedback, rate
// - Attenuation byte: flag, address, four bits
// - Latched address lets data bytes sweep frequency
// - Test reset pin pulled high internally
// - Data line 0 is the most significant
// - Three-bit address picks one of eight
// - Tone counter at clock/16, toggles output
// - Attenuation 2 dB steps, all ones off
// - Noise is XNOR-feedback shift register
module sound_generator
(
  input wire logic sys_clk,
  input wire logic srst,
  sound_bus_if.device bus,
  output logic [3:0] channel_level,
  output logic [3:0][3:0] channel_atten
);
  import sound_pkg::*;

  typedef enum logic [1:0] {IDLE, HOLD, LOAD, DONE} xfer_t;

  typedef struct packed {
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic wr_meta;
    logic wr_sync;
    logic rst_meta;
    logic rst_sync;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    xfer_t xfer;
    logic [5:0] load_count;
    logic [7:0] captured;
    logic ready_oe;
    logic [2:0] latched_addr;
    logic [2:0][9:0] freq;
    logic [3:0][3:0] atten;
    logic noise_feedback_select;
    logic noise_rate_high_bit;
    logic noise_rate_low_bit;
    logic [PRESCALE_BITS-1:0] prescale;
    logic [2:0][9:0] tone_count;
    logic [2:0] tone_wave;
    logic tone3_prev;
    logic [NOISE_WIDTH-1:0] noise_shift;
    logic [3:0] level;
  } state_t;

  state_t s;
  state_t next_s;
  state_t rst_s;
  logic [7:0] byte_val;
  logic tone_tick;
  logic noise_tick;
  logic [1:0] rate;

  // ********************************************************************
  // Numeric view of the bus byte
  // ********************************************************************
  // Data line 0 becomes bit 7 of the numeric byte.
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_bits
      assign byte_val[7-i] = s.captured[i];
    end
  endgenerate

  // Reset image: tones silent, noise seeded, pins seen released.
  always_comb
  begin
    rst_s = '0;
    rst_s.sel_meta = 1'b1;
    rst_s.sel_sync = 1'b1;
    rst_s.sel_prev = 1'b1;
    rst_s.wr_meta = 1'b1;
    rst_s.wr_sync = 1'b1;
    rst_s.rst_meta = 1'b1;
    rst_s.rst_sync = 1'b1;
    rst_s.xfer = IDLE;
    rst_s.freq = {3{FREQ_RESET}};
    rst_s.atten = {4{ATTEN_RESET}};
    rst_s.noise_shift = NOISE_SEED;
  end

  // ********************************************************************
  // Rate enables
  // ********************************************************************
  // Tone enables and noise rates 0 to 2 come from one free prescaler; noise rate 3 steps on tone 3 rising edges.
  always_comb
  begin
    rate = {s.noise_rate_high_bit, s.noise_rate_low_bit};
    tone_tick = &s.prescale[$clog2(TONE_PRESCALE)-1:0];
    unique case (rate)
      2'h0: noise_tick = &s.prescale[$clog2(NOISE_DIV_0)-1:0];
      2'h1: noise_tick = &s.prescale[$clog2(NOISE_DIV_1)-1:0];
      2'h2: noise_tick = &s.prescale[$clog2(NOISE_DIV_2)-1:0];
      RATE_FROM_TONE3: noise_tick = s.tone_wave[2] & ~s.tone3_prev;
    endcase
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  // Synchronisers, loader, register writes and generators.
  always_comb
  begin
    next_s = s;
    next_s.sel_meta = bus.select_n;
    next_s.sel_sync = s.sel_meta;
    next_s.sel_prev = s.sel_sync;
    next_s.wr_meta = bus.write_n;
    next_s.wr_sync = s.wr_meta;
    next_s.rst_meta = bus.master_reset_n;
    next_s.rst_sync = s.rst_meta;
    next_s.data_meta = bus.parallel_data_lines;
    next_s.data_sync = s.data_meta;

    // Noise shift first, so a control write reseeds over a same-cycle tick.
    if (noise_tick)
    begin
      next_s.noise_shift = {s.noise_feedback_select ?
        ~(s.noise_shift[0] ^ s.noise_shift[1]) : s.noise_shift[0],
        s.noise_shift[NOISE_WIDTH-1:1]};
    end

    // Byte loader and wait handshake.
    unique case (s.xfer)
      IDLE:
      begin
        if (s.sel_prev && !s.sel_sync)
        begin
          next_s.ready_oe = 1'b1;
          next_s.xfer = HOLD;
        end
      end
      HOLD:
      begin
        if (s.sel_sync)
        begin
          next_s.ready_oe = 1'b0;
          next_s.xfer = IDLE;
        end
        else if (!s.wr_sync)
        begin
          next_s.captured = s.data_sync;
          next_s.load_count = 6'(LOAD_CYCLES - 1);
          next_s.xfer = LOAD;
        end
      end
      LOAD:
      begin
        if (s.load_count != 6'h00)
        begin
          next_s.load_count = s.load_count - 6'h01;
        end
        else
        begin
          next_s.ready_oe = 1'b0;
          next_s.xfer = DONE;
          if (byte_val[LATCH_BIT])
          begin
            // Register byte: address is kept for later data bytes.
            next_s.latched_addr = byte_val[ADDR_HI:ADDR_LO];
            if (byte_val[ADDR_LO])
            begin
              next_s.atten[byte_val[ADDR_HI:ADDR_LO+1]] =
                byte_val[NIBBLE_HI:0];
            end
            else if (byte_val[ADDR_HI:ADDR_LO] == ADDR_NOISE_CTRL)
            begin
              next_s.noise_feedback_select = byte_val[FEEDBACK_BIT];
              next_s.noise_rate_high_bit = byte_val[RATE_HIGH_BIT];
              next_s.noise_rate_low_bit = byte_val[RATE_LOW_BIT];
              next_s.noise_shift = NOISE_SEED;
            end
            else
            begin
              next_s.freq[byte_val[ADDR_HI:ADDR_LO+1]][3:0] =
                byte_val[NIBBLE_HI:0];
            end
          end
          else if (!s.latched_addr[0] &&
                   s.latched_addr != ADDR_NOISE_CTRL)
          begin
            // Data byte: upper six bits of the latched tone.
            next_s.freq[s.latched_addr[2:1]][9:4] =
              byte_val[SIX_HI:0];
          end
        end
      end
      DONE:
      begin
        if (s.sel_sync)
        begin
          next_s.xfer = IDLE;
        end
      end
    endcase

    // Tone generators: reload and toggle when the count is one or zero.
    next_s.prescale = s.prescale + 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      if (tone_tick)
      begin
        if (s.tone_count[i] <= 10'h001)
        begin
          next_s.tone_count[i] = s.freq[i];
          next_s.tone_wave[i] = ~s.tone_wave[i];
        end
        else
        begin
          next_s.tone_count[i] = s.tone_count[i] - 10'h001;
        end
      end
    end
    next_s.tone3_prev = s.tone_wave[2];

    // Channel levels are muted by the off code.
    for (int i = 0; i < 3; i++)
    begin
      next_s.level[i] = s.tone_wave[i] & (s.atten[i] != ATTEN_OFF);
    end
    next_s.level[3] = s.noise_shift[0] & (s.atten[3] != ATTEN_OFF);

    // Test reset clears all but the select and test reset synchronisers.
    if (!s.rst_sync)
    begin
      next_s = rst_s;
      next_s.sel_meta = bus.select_n;
      next_s.sel_sync = s.sel_meta;
      next_s.rst_meta = bus.master_reset_n;
      next_s.rst_sync = s.rst_meta;
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s <= rst_s;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign bus.ready_drive = 1'b0;
  assign bus.ready_oe = s.ready_oe;
  assign channel_level = s.level;
  assign channel_atten = s.atten;

endmodule
`default_nettype wire

// file: rtl/sound_pkg.sv
// Purpose: Shared constants for the tone and noise sound generator.
// Assumes: One 100 MHz system clock on both ends.
// Notes: Byte fields are given in the numeric view of a bus byte, in
//        which data line 0 is bit 7 and data line 7 is bit 0.
package sound_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int LOAD_CYCLES = 32;
  localparam int TONE_PRESCALE = 16;
  localparam int NOISE_DIV_0 = 512;
  localparam int NOISE_DIV_1 = 1024;
  localparam int NOISE_DIV_2 = 2048;
  localparam int PRESCALE_BITS = $clog2(NOISE_DIV_2);
  localparam int HOST_GAP_CYCLES = 4;

  // ********************************************************************
  // Byte fields, numeric view
  // ********************************************************************
  localparam int LATCH_BIT = 7;
  localparam int ADDR_HI = 6;
  localparam int ADDR_LO = 4;
  localparam int NIBBLE_HI = 3;
  localparam int SIX_HI = 5;
  localparam int FEEDBACK_BIT = 2;
  localparam int RATE_LOW_BIT = 1;
  localparam int RATE_HIGH_BIT = 0;

  // ********************************************************************
  // Register addresses, codes and reset values
  // ********************************************************************
  localparam logic [2:0] ADDR_NOISE_CTRL = 3'h6;
  localparam logic [1:0] RATE_FROM_TONE3 = 2'h3;
  localparam logic [3:0] ATTEN_OFF = 4'hf;
  localparam logic [3:0] ATTEN_RESET = 4'hf;
  localparam logic [9:0] FREQ_RESET = 10'h000;
  localparam int NOISE_WIDTH = 15;
  localparam logic [NOISE_WIDTH-1:0] NOISE_SEED = 15'h4000;

endpackage

// file: rtl/sound_bus_if.sv
// Purpose: Parallel write bus between a CPU end and the sound generator.
// Assumes: Both ends run on the same system clock.
// Notes: The wait line and the test reset are resolved here with pull-ups.
`timescale 1ns/1ps
`default_nettype none
interface sound_bus_if;
  logic select_n;
  logic write_n;
  logic [7:0] parallel_data_lines;
  logic ready_drive;
  logic ready_oe;
  logic ready;
  logic reset_drive_n;
  logic reset_oe;
  logic master_reset_n;

  // Open-collector wait line and test reset, both pulled high.
  assign ready = ready_oe ? ready_drive : 1'b1;
  assign master_reset_n = reset_oe ? reset_drive_n : 1'b1;

  modport device (
    input select_n, write_n, parallel_data_lines, master_reset_n,
    output ready_drive, ready_oe
  );
  modport host (
    output select_n, write_n, parallel_data_lines, reset_drive_n,
    output reset_oe,
    input ready
  );
endinterface
`default_nettype wire

// file: rtl/sound_cpu_port.sv
// Purpose: CPU end: sends one byte at a time over the parallel bus.
// Assumes: User bytes arrive already formatted, numeric bit 7 first.
// Notes: The test reset line is left released.
`timescale 1ns/1ps
`default_nettype none
module sound_cpu_port
(
  input wire logic sys_clk,
  input wire logic srst,
  sound_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready
);
  import sound_pkg::*;

  typedef enum logic [2:0] {IDLE, SETUP, STROBE, WAIT_HI, GAP} host_t;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic [7:0] data;
    logic ready_meta;
    logic ready_sync;
    host_t state;
    logic [2:0] gap_count;
    logic cmd_ready;
  } state_t;

  state_t s;
  state_t next_s;
  logic [7:0] line_view;

  // Numeric bit 7 goes out on data line 0.
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_bits
      assign line_view[i] = cmd_byte[7-i];
    end
  endgenerate

  // Byte transfer sequence.
  always_comb
  begin
    next_s = s;
    next_s.ready_meta = bus.ready;
    next_s.ready_sync = s.ready_meta;
    unique case (s.state)
      IDLE:
      begin
        if (cmd_valid)
        begin
          next_s.data = line_view;
          next_s.sel_n = 1'b0;
          next_s.cmd_ready = 1'b0;
          next_s.state = SETUP;
        end
      end
      SETUP:
      begin
        next_s.wr_n = 1'b0;
        next_s.state = STROBE;
      end
      STROBE:
      begin
        if (!s.ready_sync)
        begin
          next_s.state = WAIT_HI;
        end
      end
      WAIT_HI:
      begin
        if (s.ready_sync)
        begin
          next_s.sel_n = 1'b1;
          next_s.wr_n = 1'b1;
          next_s.gap_count = 3'(HOST_GAP_CYCLES - 1);
          next_s.state = GAP;
        end
      end
      GAP:
      begin
        if (s.gap_count == 3'h0)
        begin
          next_s.cmd_ready = 1'b1;
          next_s.state = IDLE;
        end
        else
        begin
          next_s.gap_count = s.gap_count - 3'h1;
        end
      end
      default:
      begin
        next_s.state = IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s <= '{sel_n: 1'b1, wr_n: 1'b1, data: 8'h00, ready_meta: 1'b1,
             ready_sync: 1'b1, state: IDLE, gap_count: 3'h0,
             cmd_ready: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign bus.select_n = s.sel_n;
  assign bus.write_n = s.wr_n;
  assign bus.parallel_data_lines = s.data;
  assign bus.reset_drive_n = 1'b1;
  assign bus.reset_oe = 1'b0;
  assign cmd_ready = s.cmd_ready;

endmodule
`default_nettype wire

// file: sim/sound_bus_sva.sv
// Purpose: Protocol checks on the bus between the two sound ends.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees the resolved bus signals and the wait line drive enable ready_oe.
`timescale 1ns/1ps
`default_nettype none
module sound_bus_sva
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic [7:0] parallel_data_lines,
  input wire logic ready_oe,
  input wire logic ready,
  input wire logic master_reset_n
);
  logic [7:0] hi_cnt;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Counts the cycles for which the wait line has been pulled low.
  always_ff @(posedge sys_clk)
  begin
    if (srst || !ready_oe)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= hi_cnt + 8'h01;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  // Wait timing, bus holding and select framing.
  property p_wait_prompt;
    $fell(select_n) |-> ##[1:6] ready_oe;
  endproperty
  a_wait_prompt: assert property (p_wait_prompt)
    else $error("Wait line not pulled after select fell.");
  property p_load_len;
    $fell(ready_oe) |-> (hi_cnt >= 8'h20) && (hi_cnt <= 8'h28);
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("Wait line held for a wrong number of cycles.");
  property p_ready_bound;
    $rose(ready_oe) |-> ##[32:41] !ready_oe;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("Wait line never released.");
  property p_host_hold;
    $past(!ready) && !ready |-> $stable(select_n) && $stable(write_n)
      && $stable(parallel_data_lines);
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("Bus changed while wait was low.");
  property p_release;
    $rose(select_n) |-> $past(ready);
  endproperty
  a_release: assert property (p_release)
    else $error("Select released before wait went high.");
  property p_sel_ready;
    ready_oe |-> !select_n;
  endproperty
  a_sel_ready: assert property (p_sel_ready)
    else $error("Wait pulled without select.");
  property p_strobe;
    !write_n |-> !select_n && $past(!select_n);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("Strobe outside a selected transfer.");
  property p_reset_pin;
    master_reset_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("Test reset line left its pulled-up level.");

  // Main traffic seen.
  c_wait: cover property ($rose(ready_oe));
  c_strobe: cover property ($fell(write_n));
  c_done: cover property ($rose(select_n));
endmodule
`default_nettype wire

// file: sim/tone_noise_sound_generator_tb.sv
// Purpose: Self-checking bench joining the CPU end to the generator.
// Assumes: 100 MHz clock, bytes sent through the CPU end user port.
// Notes: Tone and noise timing is judged from the channel levels.
`timescale 1ns/1ps
`default_nettype none
module tone_noise_sound_generator_tb;
  import sound_pkg::*;
  logic sys_clk;
  logic srst;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_ready;
  logic [3:0] channel_level;
  logic [3:0][3:0] channel_atten;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  sound_bus_if bus ();
  sound_cpu_port i_sound_cpu_port (.sys_clk(sys_clk), .srst(srst),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready));
  sound_generator i_sound_generator (.sys_clk(sys_clk), .srst(srst),
    .bus(bus), .channel_level(channel_level),
    .channel_atten(channel_atten));
  sound_bus_sva i_sound_bus_sva (.sys_clk(sys_clk), .srst(srst),
    .select_n(bus.select_n), .write_n(bus.write_n),
    .parallel_data_lines(bus.parallel_data_lines),
    .ready_oe(bus.ready_oe), .ready(bus.ready),
    .master_reset_n(bus.master_reset_n));

  // Free-running system clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cuts a hung run short.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      error_cnt++;
      results();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task step;
    @(posedge sys_clk);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Sends one byte and checks its wire order while the strobe is low.
  task send(input logic [7:0] b);
    logic [7:0] lines;
    int n;
    lines = {<<{b}};
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    cmd_valid = 1'b1;
    cmd_byte = b;
    step();
    cmd_valid = 1'b0;
    while (bus.write_n !== 1'b0 && n < 300)
    begin
      step();
      n++;
    end
    chk(32'(bus.parallel_data_lines), 32'(lines));
    while (cmd_ready !== 1'b1 && n < 300)
    begin
      step();
      n++;
    end
    chk(32'(n < 300), 32'h1);
  endtask

  // Spacing between two level changes, after two settling changes.
  task edge_gap(input int idx, output logic [31:0] gap);
    logic prev;
    for (int e = 0; e < 3; e++)
    begin
      prev = channel_level[idx];
      gap = 0;
      do
      begin
        step();
        gap++;
      end
      while (channel_level[idx] === prev && gap < 5000);
    end
  endtask

  // Length of the next high run of the noise level, capped.
  task high_width(output logic [31:0] w);
    int n;
    n = 0;
    while (channel_level[3] !== 1'b1 && n < 40000)
    begin
      step();
      n++;
    end
    w = 0;
    while (channel_level[3] === 1'b1 && w < 8000)
    begin
      step();
      w++;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    chk(32'(channel_atten), 32'({4{ATTEN_RESET}}));
    chk(32'(channel_level), 32'h0);
  endtask

  task t_atten;
    for (int k = 0; k < 4; k++)
      send({1'b1, 3'(2 * k + 1), 4'(k)});
    chk(32'(channel_atten), 32'h3210);
  endtask

  task t_tone;
    logic [31:0] gap;
    logic acc;
    send(8'h83);
    send(8'h00);
    edge_gap(0, gap);
    chk(gap, 32'(3 * TONE_PRESCALE));
    send(8'h01);
    edge_gap(0, gap);
    chk(gap, 32'(19 * TONE_PRESCALE));
    send(8'h90);
    send(8'h3f);
    edge_gap(0, gap);
    chk(gap, 32'(19 * TONE_PRESCALE));
    send(8'h9f);
    acc = 1'b0;
    repeat (700)
    begin
      step();
      acc = acc | channel_level[0];
    end
    chk(32'(acc), 32'h0);
  endtask

  task t_noise;
    logic [31:0] w;
    logic [31:0] exp;
    logic [1:0] r;
    send(8'hc2);
    send(8'h00);
    edge_gap(2, w);
    chk(w, 32'(2 * TONE_PRESCALE));
    edge_gap(1, w);
    chk(w, 32'(TONE_PRESCALE));
    for (int i = 0; i < 4; i++)
    begin
      r = 2'(i);
      exp = (i == 3) ? 32'(4 * TONE_PRESCALE) : 32'(NOISE_DIV_0 << i);
      send({5'b11100, 1'b0, r[0], r[1]});
      high_width(w);
      chk(w, exp);
    end
    send(8'he4);
    high_width(w);
    chk(w, 32'(14 * NOISE_DIV_0));
  endtask

  // Main sequence.
  initial
  begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    repeat (10) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_atten();
    t_tone();
    t_noise();
    results();
  end
endmodule
`default_nettype wire
